// File: tccc_control.sv
`timescale 1ns/100ps
`default_nettype none
module tccc_control #(
  parameter bit HAS_CONTROL_REG = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        bus_wr_en,
  input  wire logic        bus_bit_wr,
  input  wire logic        bus_rd_en,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wr_data,
  input  wire logic [2:0]  bus_bit_sel,
  input  wire logic        bus_bit_val,
  output logic      [7:0]  bus_rd_data,
  input  wire logic        count_en,
  input  wire logic [1:0]  run_mode,
  input  wire logic [1:0]  edge_sel_a,
  input  wire logic [1:0]  edge_sel_b,
  input  wire logic [15:0] timer_counter_value,
  input  wire logic        timer_input_a,
  input  wire logic        timer_input_b,
  output logic      [15:0] first_cc_register,
  output logic      [15:0] second_cc_register,
  output logic             first_reg_capture,
  output logic             second_reg_capture,
  output logic             first_cc_interrupt
);
  logic [7:0]  ctrl_q, ctrl_d, rd_d;
  logic [15:0] first_q, first_d, second_q, second_d;
  logic        irq_q, irq_d;
  logic        a_valid, a_rev, b_valid;
  logic        hit, first_trig, subst, first_cap, second_cap;

  tccc_edge u_edge_a (
    .clock     (clock),
    .srst      (srst),
    .sample_en (count_en),
    .pin       (timer_input_a),
    .edge_sel  (edge_sel_a),
    .valid_q   (a_valid),
    .reverse_q (a_rev)
  );

  tccc_edge u_edge_b (
    .clock     (clock),
    .srst      (srst),
    .sample_en (count_en),
    .pin       (timer_input_b),
    .edge_sel  (edge_sel_b),
    .valid_q   (b_valid),
    .reverse_q ()
  );

  // register access
  always_comb begin
    hit = (bus_addr == tccc_pkg::CC_CTRL_ADDR);
    ctrl_d = ctrl_q;
    if (bus_wr_en && hit) begin
      ctrl_d = bus_wr_data;
    end else if (bus_bit_wr && hit) begin
      ctrl_d[bus_bit_sel] = bus_bit_val;
    end
    ctrl_d = ctrl_d & tccc_pkg::CC_CTRL_MASK;
    if (!HAS_CONTROL_REG) begin
      ctrl_d = tccc_pkg::CC_CTRL_RESET;
    end
    rd_d = (bus_rd_en && hit) ? ctrl_q : 8'h00;
  end

  // capture path
  always_comb begin
    first_trig = ctrl_q[tccc_pkg::TRIG_SEL_BIT] ? a_rev : b_valid;
    subst = ctrl_q[tccc_pkg::TRIG_SEL_BIT] & b_valid;
    first_cap = ctrl_q[tccc_pkg::FIRST_MODE_BIT] & first_trig;
    second_cap = ctrl_q[tccc_pkg::SECOND_MODE_BIT] & a_valid;
    first_d = first_cap ? timer_counter_value : first_q;
    second_d = second_cap ? timer_counter_value : second_q;
    irq_d = subst | first_cap;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_q <= tccc_pkg::CC_CTRL_RESET;
      bus_rd_data <= 8'h00;
      first_q <= tccc_pkg::COUNT_RESET;
      second_q <= tccc_pkg::COUNT_RESET;
      irq_q <= 1'b0;
      first_reg_capture <= 1'b0;
      second_reg_capture <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      bus_rd_data <= rd_d;
      first_q <= first_d;
      second_q <= second_d;
      irq_q <= irq_d;
      first_reg_capture <= ctrl_d[tccc_pkg::FIRST_MODE_BIT];
      second_reg_capture <= ctrl_d[tccc_pkg::SECOND_MODE_BIT];
    end
  end

  always_comb begin
    first_cc_register = first_q;
    second_cc_register = second_q;
    first_cc_interrupt = irq_q;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence byte_wr_s;
    HAS_CONTROL_REG && bus_wr_en && hit;
  endsequence

  sequence bit_wr_s;
    HAS_CONTROL_REG && !bus_wr_en && bus_bit_wr && hit && (bus_bit_sel < 3'h3);
  endsequence

  sequence subst_s;
    ctrl_q[tccc_pkg::TRIG_SEL_BIT] && b_valid;
  endsequence

  sequence b_capture_s;
    !ctrl_q[tccc_pkg::TRIG_SEL_BIT] && ctrl_q[tccc_pkg::FIRST_MODE_BIT] && b_valid;
  endsequence

  reset_clear_a: assert property ($past(srst) |-> ctrl_q == 8'h00 && !first_reg_capture)
    else $error("control not cleared by reset");
  byte_write_a: assert property (byte_wr_s |=> ctrl_q == ($past(bus_wr_data) & 8'h07))
    else $error("byte write not stored");
  bit_write_a: assert property (bit_wr_s |=> ctrl_q[$past(bus_bit_sel)] == $past(bus_bit_val))
    else $error("bit write not stored");
  upper_zero_a: assert property (ctrl_q[7:3] == 5'h00 ##1 bus_rd_data[7:3] == 5'h00)
    else $error("upper control bits not zero");
  compare_hold_a: assert property (!ctrl_q[0] && !ctrl_q[2]
                                   |=> $stable(first_q) && $stable(second_q))
    else $error("compare register changed by capture");
  both_none_a: assert property (edge_sel_a == 2'h3 |=> !a_rev)
    else $error("reverse edge seen with both edges");
  subst_irq_a: assert property (subst_s |=> first_cc_interrupt && $stable(first_q))
    else $error("external interrupt substitution failed");
  b_capture_a: assert property (b_capture_s |=> first_q == $past(timer_counter_value)
                                && first_cc_interrupt)
    else $error("first register missed input b capture");
  second_capture_a: assert property (ctrl_q[2] && a_valid
                                     |=> second_q == $past(timer_counter_value))
    else $error("second register missed capture");
  reduced_build_a: assert property (!HAS_CONTROL_REG |-> ctrl_q == 8'h00)
    else $error("reduced build control not zero");

  sequence rev_capture_s;
    ctrl_q[tccc_pkg::TRIG_SEL_BIT] && ctrl_q[tccc_pkg::FIRST_MODE_BIT] && a_rev;
  endsequence

  sequence rd_hit_s;
    bus_rd_en && hit;
  endsequence

  sequence bit_high_s;
    !bus_wr_en && bus_bit_wr && hit && (bus_bit_sel >= 3'h3);
  endsequence

  sequence no_write_s;
    !((bus_wr_en || bus_bit_wr) && hit);
  endsequence

  sequence both_rev_s;
    edge_sel_a == tccc_pkg::EDGE_BOTH ##1 ctrl_q[tccc_pkg::TRIG_SEL_BIT];
  endsequence

  sequence b_compare_s;
    !ctrl_q[tccc_pkg::TRIG_SEL_BIT] && !ctrl_q[tccc_pkg::FIRST_MODE_BIT] && b_valid;
  endsequence

  rev_capture_a: assert property (rev_capture_s |=> first_q == $past(timer_counter_value))
    else $error("first register missed reverse edge capture");

  rev_irq_a: assert property (rev_capture_s |=> first_cc_interrupt)
    else $error("reverse edge capture raised no interrupt");

  both_rev_a: assert property (both_rev_s |=> $stable(first_q))
    else $error("capture on input a with both edges and reverse phase");

  b_compare_a: assert property (b_compare_s |=> !first_cc_interrupt)
    else $error("interrupt from input b in compare mode");

  first_hold_a: assert property (!ctrl_q[tccc_pkg::FIRST_MODE_BIT] |=> $stable(first_q))
    else $error("first compare register changed");

  second_hold_a: assert property (!ctrl_q[tccc_pkg::SECOND_MODE_BIT] |=> $stable(second_q))
    else $error("second compare register changed");

  mode_out_a: assert property (first_reg_capture == ctrl_q[tccc_pkg::FIRST_MODE_BIT]
                               && second_reg_capture == ctrl_q[tccc_pkg::SECOND_MODE_BIT])
    else $error("mode outputs differ from control");

  reset_outputs_a: assert property ($past(srst) |-> first_q == tccc_pkg::COUNT_RESET
                                    && second_q == tccc_pkg::COUNT_RESET
                                    && !first_cc_interrupt && bus_rd_data == 8'h00)
    else $error("outputs not cleared by reset");

  read_data_a: assert property (rd_hit_s |=> bus_rd_data == $past(ctrl_q))
    else $error("read data differs from control");

  read_idle_a: assert property (!(bus_rd_en && hit) |=> bus_rd_data == 8'h00)
    else $error("read data not zero without a read");

  bit_high_a: assert property (bit_high_s |=> $stable(ctrl_q))
    else $error("bit write above bit 2 changed control");

  ctrl_hold_a: assert property (no_write_s |=> $stable(ctrl_q))
    else $error("control changed without a write");

  edge_none_a: assert property (edge_sel_a == tccc_pkg::EDGE_NONE |=> !a_valid && !a_rev)
    else $error("edge seen on input a with no edge selected");

  b_none_a: assert property (edge_sel_b == tccc_pkg::EDGE_NONE |=> !b_valid)
    else $error("edge seen on input b with no edge selected");

  irq_cause_a: assert property (first_cc_interrupt |-> $past(b_valid) || $past(a_rev))
    else $error("interrupt without a pin edge");

endmodule // tccc_control
`default_nettype wire

// File: tccc_pkg.sv
// Function
// - the control register takes single-bit writes and whole-byte writes.
// - reset clears the control register, so both registers start as compare registers.
// - trigger select 0 captures on input b; 1 on reverse edge of input a.
// - valid edges of both inputs come from the prescaler edge-select fields.
// - both-edges select on input a with reverse phase detects no edge.
// - reverse phase turns input b edges into an external interrupt, no capture.
// - a build without the control register keeps both registers compare only.
`default_nettype none
package tccc_pkg;
  localparam logic [15:0] CC_CTRL_ADDR    = 16'hffbc;
  localparam logic [7:0]  CC_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  CC_CTRL_MASK    = 8'h07;
  localparam int          FIRST_MODE_BIT  = 0;
  localparam int          TRIG_SEL_BIT    = 1;
  localparam int          SECOND_MODE_BIT = 2;
  localparam logic [1:0]  EDGE_FALL       = 2'h0;
  localparam logic [1:0]  EDGE_RISE       = 2'h1;
  localparam logic [1:0]  EDGE_NONE       = 2'h2;
  localparam logic [1:0]  EDGE_BOTH       = 2'h3;
  localparam logic [1:0]  RUN_STOP        = 2'h0;
  localparam logic [1:0]  RUN_CLEAR_MATCH = 2'h3;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
endpackage
`default_nettype wire

// File: tccc_edge.sv
`timescale 1ns/100ps
`default_nettype none
module tccc_edge (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       sample_en,
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  output logic            valid_q,
  output logic            reverse_q
);
  logic s1_q, s2_q, s3_q, level_q, prev_q;
  logic level_d, prev_d, valid_d, reverse_d, rise, fall;

  always_comb begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
    prev_d = sample_en ? level_q : prev_q;
    rise = sample_en & level_q & ~prev_q;
    fall = sample_en & ~level_q & prev_q;
    case (edge_sel)
      tccc_pkg::EDGE_FALL: begin
        valid_d = fall;
        reverse_d = rise;
      end
      tccc_pkg::EDGE_RISE: begin
        valid_d = rise;
        reverse_d = fall;
      end
      tccc_pkg::EDGE_BOTH: begin
        valid_d = rise | fall;
        reverse_d = 1'b0;
      end
      default: begin
        valid_d = 1'b0;
        reverse_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
      prev_q <= 1'b0;
      valid_q <= 1'b0;
      reverse_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
      prev_q <= prev_d;
      valid_q <= valid_d;
      reverse_q <= reverse_d;
    end
  end
endmodule // tccc_edge
`default_nettype wire

// File: tccc_pins.sv
`timescale 1ns/100ps
`default_nettype none
module tccc_pins #(
  parameter int HOLD = 12
) (
  input  wire logic clock,
  output logic      pin_a,
  output logic      pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // one edge, then the level holds beyond two count periods
  task automatic toggle(input bit sel_b);
    @(posedge clock);
    if (sel_b)
      pin_b <= ~pin_b;
    else
      pin_a <= ~pin_a;
    repeat (HOLD) @(posedge clock);
  endtask
endmodule // tccc_pins
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clock = 1'b0, srst = 1'b1, we = 1'b0, bw = 1'b0, re = 1'b0, bv = 1'b0;
  logic        ce = 1'b0, pa, pb, m1, m2, irq, seen, seen2;
  logic [15:0] addr = 16'h0000, cnt = 16'h0000, r1, r2, at, at2;
  logic [7:0]  wd = 8'h00, rd;
  logic [2:0]  bs = 3'h0;
  logic [1:0]  esa = 2'h1, esb = 2'h1, rm = tccc_pkg::RUN_STOP;
  int          n_fail = 0, checks = 0, cyc = 0;
  localparam logic [15:0] A = tccc_pkg::CC_CTRL_ADDR;
  tccc_pins pins (.clock(clock), .pin_a(pa), .pin_b(pb));
  tccc_control DUT (.clock(clock), .srst(srst), .bus_wr_en(we), .bus_bit_wr(bw),
    .bus_rd_en(re), .bus_addr(addr), .bus_wr_data(wd), .bus_bit_sel(bs), .bus_bit_val(bv),
    .bus_rd_data(rd), .count_en(ce), .run_mode(rm), .edge_sel_a(esa),
    .edge_sel_b(esb), .timer_counter_value(cnt), .timer_input_a(pa), .timer_input_b(pb),
    .first_cc_register(r1), .second_cc_register(r2), .first_reg_capture(m1),
    .second_reg_capture(m2), .first_cc_interrupt(irq));
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cnt <= cnt + 16'h0001;
    ce  <= (cnt[1:0] == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED time %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clock);
    we   <= 1'b1;
    addr <= A;
    wd   <= d;
    @(posedge clock);
    we <= 1'b0;
  endtask
  task automatic bitwr(input logic [2:0] s, input logic v);
    @(posedge clock);
    bw   <= 1'b1;
    bs   <= s;
    bv   <= v;
    addr <= A;
    @(posedge clock);
    bw <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    re   <= 1'b1;
    addr <= a;
    @(posedge clock);
    re <= 1'b0;
    #1;
    check({8'h00, rd}, {8'h00, e});
  endtask
  // toggles one pin and watches the interrupt and both registers
  task automatic pulse(input bit sel_b, input bit e_irq, input bit e_cap, input bit e_sec);
    logic [15:0] old, old2;
    old   = r1;
    old2  = r2;
    seen  = 1'b0;
    seen2 = 1'b0;
    fork
      pins.toggle(sel_b);
      repeat (20) begin
        @(posedge clock);
        #1;
        if (irq === 1'b1 && !seen) begin
          seen = 1'b1;
          at   = cnt - 16'h0001;
        end
        if (r2 !== old2 && !seen2) begin
          seen2 = 1'b1;
          at2   = cnt - 16'h0001;
        end
      end
    join
    check({15'h0000, seen}, {15'h0000, e_irq});
    check(r1, e_cap ? at : old);
    check(r2, e_sec ? at2 : old2);
  endtask
  task automatic regs();
    rdchk(A, 8'h00);
    check({r2[13:0], m1, m2}, 16'h0000);
    wr(8'hff);
    rdchk(A, 8'h07);
    rdchk(16'hffbd, 8'h00);
    bitwr(3'h1, 1'b0);
    bitwr(3'h5, 1'b1);
    rdchk(A, 8'h05);
    check({14'h0000, m1, m2}, 16'h0003);
  endtask
  task automatic capt();
    wr(8'h01);
    pulse(1'b1, 1'b1, 1'b1, 1'b0);
    @(posedge clock);
    esb <= 2'h0;
    pulse(1'b1, 1'b1, 1'b1, 1'b0);
    wr(8'h03);
    esb <= 2'h3;
    pulse(1'b1, 1'b1, 1'b0, 1'b0);
    pulse(1'b0, 1'b0, 1'b0, 1'b0);
    pulse(1'b0, 1'b1, 1'b1, 1'b0);
    @(posedge clock);
    esa <= 2'h3;
    pulse(1'b0, 1'b0, 1'b0, 1'b0);
    pulse(1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic second();
    wr(8'h01);
    esb <= tccc_pkg::EDGE_NONE;
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    wr(8'h04);
    rm <= tccc_pkg::RUN_CLEAR_MATCH;
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    @(posedge clock);
    rm <= tccc_pkg::RUN_STOP;
  endtask
  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    regs();
    capt();
    second();
    test_done();
  end
endmodule // testbench
`default_nettype wire
